/* File: test/tb.sv */
/*
  Self-checking bench for the capture and compare flag block.
  Assumes ccf_map.svh and ccf_pkg are compiled first; drives the top alone.
*/
`timescale 1ns/100ps
`include "ccf_map.svh"
module tb;
  logic        hclk      = 1'b0;
  logic        hresetn   = 1'b0;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [2:0]  hsize     = 3'h2;
  logic [31:0] hwdata    = 32'h0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [4:0]  cap_event = 5'h0;
  logic [4:0]  cmp_match = 5'h0;
  logic [4:0]  pwm_out   = 5'h1f;
  logic        chan1_event_flag;
  logic        chan2_event_flag;
  logic        chan3_event_flag;
  logic        chan4_event_flag;
  logic        chan5_event_flag;
  logic        irq;
  logic [4:0]  flg;
  logic        dp_rd     = 1'b0;
  logic [31:0] exp_q[$];
  int          error_cnt = 0;
  int          compares  = 0;

  // Free-running 125 MHz clock.
  always #4 hclk = ~hclk;

  // Flag outputs gathered, channel 1 in bit 0.
  assign flg = {chan5_event_flag, chan4_event_flag, chan3_event_flag,
                chan2_event_flag, chan1_event_flag};

  // The one slave drives the bus ready itself.
  ccf_irq_top uut (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .hsel             (hsel),
    .haddr            (haddr),
    .htrans           (htrans),
    .hwrite           (hwrite),
    .hsize            (hsize),
    .hwdata           (hwdata),
    .hready           (hreadyout),
    .hreadyout        (hreadyout),
    .hresp            (hresp),
    .hrdata           (hrdata),
    .cap_event        (cap_event),
    .cmp_match        (cmp_match),
    .pwm_out          (pwm_out),
    .chan1_event_flag (chan1_event_flag),
    .chan2_event_flag (chan2_event_flag),
    .chan3_event_flag (chan3_event_flag),
    .chan4_event_flag (chan4_event_flag),
    .chan5_event_flag (chan5_event_flag),
    .irq              (irq)
  );

  // Compares one value and counts it.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic final_report();
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Waits for ready at a rising edge; only the watchdog ends a hang.
  task automatic wait_rdy();
    do
      @(posedge hclk);
    while (hreadyout !== 1'b1);
  endtask

  // One single word transfer; a read notes its expected data.
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d, input logic [2:0] sz,
                      input logic [31:0] e);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= sz;
    if (!w)
      exp_q.push_back(e);
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask

  // Drives channel inputs for one cycle; pulses drop afterwards.
  task automatic ev_drive(input logic [4:0] c, input logic [4:0] m,
                          input logic [4:0] p);
    cap_event <= c;
    cmp_match <= m;
    pwm_out   <= p;
    @(posedge hclk);
    cap_event <= 5'h0;
    cmp_match <= 5'h0;
  endtask

  // Checks the interrupt output once it has settled.
  task automatic irq_is(input logic e);
    repeat (2) @(posedge hclk);
    #1;
    check({31'h0, irq}, {31'h0, e});
    @(posedge hclk);
  endtask

  // Takes the oldest note off the queue when read data completes.
  always @(posedge hclk)
  begin
    if (dp_rd && hreadyout === 1'b1 && exp_q.size() > 0)
    begin
      check(hrdata, exp_q.pop_front());
      check({31'h0, hresp}, 32'h0);
    end
    if (hreadyout === 1'b1)
      dp_rd <= hsel && htrans[1] && !hwrite && hsize == 3'h2;
  end

  // Cuts a hang short.
  initial
  begin
    #100us;
    error_cnt++;
    final_report();
  end

  // Main sequence.
  initial
  begin
    logic [4:0]         ev;
    logic [4:0]         ex;
    logic [9:0]         mv;
    ccf_pkg::ccf_mode_t mds[4];
    void'($urandom(11848));
    mds = '{ccf_pkg::mode_capture, ccf_pkg::mode_compare,
            ccf_pkg::mode_pwm, ccf_pkg::mode_off};
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values of every register and an unmapped word.
    for (int a = 0; a < 5; a++)
      xfer(8'(a * 4), 1'b0, 32'h0, 3'h2, 32'h0);
    // Each mode: only its own event sets flags, enables all off.
    for (int i = 0; i < 4; i++)
    begin
      ev = 5'($urandom_range(31, 1)) | 5'h01;
      ex = (i == 3) ? 5'h0 : ev;
      mv = {5{mds[i]}};
      xfer(`CCF_OFF_MODE, 1'b1, {22'h0, mv}, 3'h2, 32'h0);
      xfer(`CCF_OFF_FLAGS, 1'b1, 32'h0, 3'h2, 32'h0);
      xfer(`CCF_OFF_MODE, 1'b0, 32'h0, 3'h2, {22'h0, mv});
      if (i == 0)
        ev_drive(ev, ~ev, 5'h1f);
      else if (i == 1)
        ev_drive(~ev, ev, 5'h1f);
      else
      begin
        ev_drive(5'h0, 5'h0, 5'h1f);
        @(posedge hclk);
        ev_drive((i == 3) ? ev : ~ev, (i == 3) ? ev : ~ev, ~ev);
      end
      repeat (4) @(posedge hclk);
      #1;
      check({27'h0, flg}, {27'h0, ex});
      @(posedge hclk);
      xfer(`CCF_OFF_FLAGS, 1'b0, 32'h0, 3'h2, {27'h0, ex});
      xfer(`CCF_OFF_FLAGS, 1'b1, {27'h0, ex & 5'h15}, 3'h2, 32'h0);
      xfer(`CCF_OFF_FLAGS, 1'b0, 32'h0, 3'h2, {27'h0, ex & 5'h15});
    end
    irq_is(1'b0);
    // Interrupt needs flag, enable and both control bits.
    xfer(`CCF_OFF_MODE, 1'b1, {22'h0, {5{ccf_pkg::mode_capture}}},
         3'h2, 32'h0);
    xfer(`CCF_OFF_FLAGS, 1'b1, 32'h0, 3'h2, 32'h0);
    xfer(`CCF_OFF_ENABLE, 1'b1, 32'h4, 3'h2, 32'h0);
    ev_drive(5'h04, 5'h0, 5'h1f);
    for (int c = 0; c < 4; c++)
    begin
      xfer(`CCF_OFF_CTRL, 1'b1, 32'(c) << 6, 3'h2, 32'h0);
      irq_is(c == 3);
    end
    xfer(`CCF_OFF_ENABLE, 1'b1, 32'h1b, 3'h2, 32'h0);
    irq_is(1'b0);
    // An unmapped write leaves the mask alone.
    xfer(8'h14, 1'b1, 32'h1f, 3'h2, 32'h0);
    xfer(`CCF_OFF_ENABLE, 1'b0, 32'h0, 3'h2, 32'h1b);
    xfer(`CCF_OFF_ENABLE, 1'b1, 32'h4, 3'h2, 32'h0);
    irq_is(1'b1);
    // Clearing the flag drops the request; unmapped writes vanish.
    xfer(`CCF_OFF_FLAGS, 1'b1, 32'h0, 3'h2, 32'h0);
    irq_is(1'b0);
    xfer(8'h10, 1'b1, 32'h1f, 3'h2, 32'h0);
    xfer(8'h10, 1'b0, 32'h0, 3'h2, 32'h0);
    xfer(`CCF_OFF_CTRL, 1'b0, 32'h0, 3'h2, 32'hc0);
    // A capture in the cycle of a clearing write still sets every flag.
    fork
      xfer(`CCF_OFF_FLAGS, 1'b1, 32'h0, 3'h2, 32'h0);
      begin
        @(posedge hclk);
        ev_drive(5'h1f, 5'h0, 5'h1f);
      end
    join
    #1;
    check({27'h0, flg}, 32'h1f);
    repeat (4) @(posedge hclk);
    check(32'(exp_q.size()), 32'h0);
    final_report();
  end
endmodule

/* File: verilog/ccf_evt_sel.sv */
/*
  Picks each channel's interrupt event from its mode: capture event,
  compare match, or the falling edge of the PWM output.
  Assumes all event inputs come from logic on the same clock.
*/
`timescale 1ns/100ps
module ccf_evt_sel #(
  parameter int N = 5
) (
  // Clock and reset.
  input  wire logic           hclk,
  input  wire logic           hresetn,
  // Channel side.
  input  wire logic [2*N-1:0] mode,
  input  wire logic [N-1:0]   cap_event,
  input  wire logic [N-1:0]   cmp_match,
  input  wire logic [N-1:0]   pwm_out,
  // Selected events.
  output      logic [N-1:0]   evt
);

  logic [N-1:0] pwm_prev_r;
  logic [N-1:0] pwm_prev_nxt;

  // Selects the event source for each channel from its mode.
  always_comb
  begin
    pwm_prev_nxt = pwm_out;
    evt          = '0;
    for (int i = 0; i < N; i++)
    begin
      case (ccf_pkg::ccf_mode_t'(mode[2*i +: 2]))
        ccf_pkg::mode_capture: evt[i] = cap_event[i];
        ccf_pkg::mode_compare: evt[i] = cmp_match[i];
        ccf_pkg::mode_pwm:     evt[i] = pwm_prev_r[i] & ~pwm_out[i];
        default:               evt[i] = 1'b0;
      endcase
    end
  end

  // Remembers the last PWM level for the trailing edge.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pwm_prev_r <= '0;
    else
      pwm_prev_r <= pwm_prev_nxt;
  end

endmodule

/* File: verilog/ccf_flag_bank.sv */
/*
  Sticky event flags: hardware sets, software writes.
  Assumes write strobe and data come from the bus slave on the same clock.
*/
`timescale 1ns/100ps
module ccf_flag_bank #(
  parameter int N = 5
) (
  // Clock and reset.
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Hardware set and software write.
  input  wire logic [N-1:0] set,
  input  wire logic         wr_en,
  input  wire logic [N-1:0] wr_data,
  // Flag state.
  output      logic [N-1:0] flags
);

  logic [N-1:0] flags_r;
  logic [N-1:0] flags_nxt;

  // A set in the same cycle as a clearing write wins.
  always_comb
  begin
    if (wr_en)
      flags_nxt = wr_data | set;
    else
      flags_nxt = flags_r | set;
  end

  // Registers the flags.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flags_r <= '0;
    else
      flags_r <= flags_nxt;
  end

  assign flags = flags_r;

endmodule

/* File: verilog/ccf_irq_top.sv */
/*
  Capture and compare channel interrupt flags with an AHB-Lite register
  slave, enable mask, interrupt control bits and one interrupt output.
  Assumes channel event inputs are synchronous to hclk and that it is the
  only slave on its bus segment.
*/
`timescale 1ns/100ps
`include "ccf_map.svh"
module ccf_irq_top (
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic        hreadyout,
  output      logic        hresp,
  output      logic [31:0] hrdata,
  // Channel events, bit i is channel i+1.
  input  wire logic [4:0]  cap_event,
  input  wire logic [4:0]  cmp_match,
  input  wire logic [4:0]  pwm_out,
  // Flags and interrupt.
  output      logic        chan1_event_flag,
  output      logic        chan2_event_flag,
  output      logic        chan3_event_flag,
  output      logic        chan4_event_flag,
  output      logic        chan5_event_flag,
  output      logic        irq
);

  ccf_pkg::ccf_bus_st_t st_r;
  ccf_pkg::ccf_bus_st_t st_nxt;
  logic [7:0]           addr_r;
  logic [7:0]           addr_nxt;
  logic [31:0]          hrdata_r;
  logic [31:0]          hrdata_nxt;
  logic [4:0]           enable_r;
  logic [4:0]           enable_nxt;
  logic                 global_irq_enable_r;
  logic                 global_irq_enable_nxt;
  logic                 peripheral_irq_enable_r;
  logic                 peripheral_irq_enable_nxt;
  logic [9:0]           channel_mode_select_r;
  logic [9:0]           channel_mode_select_nxt;
  logic                 irq_r;
  logic                 irq_nxt;
  logic                 accept;
  logic                 flag_wr;
  logic [4:0]           evt;
  logic [4:0]           flags;

  // Reads one register word; unmapped offsets read as zero.
  function automatic logic [31:0] read_word(input logic [7:0] a,
                                            input logic [4:0] fl,
                                            input logic [4:0] en,
                                            input logic       global_irq_enable,
                                            input logic       peripheral_irq_enable,
                                            input logic [9:0] md);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      `CCF_OFF_FLAGS:  w[4:0] = fl;
      `CCF_OFF_ENABLE: w[4:0] = en;
      `CCF_OFF_CTRL:
      begin
        w[`CCF_CTRL_GIE_BIT]  = global_irq_enable;
        w[`CCF_CTRL_PERIPHERAL_IRQ_ENABLE_BIT] = peripheral_irq_enable;
      end
      `CCF_OFF_MODE:   w[9:0] = md;
      default:         w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // Takes a word-sized transfer when the bus is ready.
  assign accept = hsel & htrans[1] & hready & (hsize == 3'h2);

  // Sequences address and data phases; reads add one wait state.
  always_comb
  begin
    st_nxt     = st_r;
    addr_nxt   = addr_r;
    hrdata_nxt = hrdata_r;
    case (st_r)
      ccf_pkg::bus_rwait:
      begin
        hrdata_nxt = read_word(addr_r, flags, enable_r,
                               global_irq_enable_r,
                               peripheral_irq_enable_r,
                               channel_mode_select_r);
        st_nxt     = ccf_pkg::bus_rdone;
      end
      ccf_pkg::bus_idle, ccf_pkg::bus_wdata, ccf_pkg::bus_rdone:
      begin
        if (accept)
        begin
          addr_nxt = {haddr[7:2], 2'b00};
          st_nxt   = hwrite ? ccf_pkg::bus_wdata : ccf_pkg::bus_rwait;
        end
        else
          st_nxt = ccf_pkg::bus_idle;
      end
      default: st_nxt = ccf_pkg::bus_idle;
    endcase
  end

  // Registers the bus slave state.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r     <= ccf_pkg::bus_idle;
      addr_r   <= 8'h00;
      hrdata_r <= 32'h0000_0000;
    end
    else
    begin
      st_r     <= st_nxt;
      addr_r   <= addr_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  // Bus answers: only the read wait state holds the bus.
  assign hreadyout = (st_r != ccf_pkg::bus_rwait);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // Software write to the flag register.
  assign flag_wr = (st_r == ccf_pkg::bus_wdata) && (addr_r == `CCF_OFF_FLAGS);

  // Applies writes to the enable, control and mode registers.
  always_comb
  begin
    enable_nxt                = enable_r;
    global_irq_enable_nxt     = global_irq_enable_r;
    peripheral_irq_enable_nxt = peripheral_irq_enable_r;
    channel_mode_select_nxt   = channel_mode_select_r;
    if (st_r == ccf_pkg::bus_wdata)
    begin
      case (addr_r)
        `CCF_OFF_ENABLE: enable_nxt = hwdata[4:0];
        `CCF_OFF_CTRL:
        begin
          global_irq_enable_nxt     = hwdata[`CCF_CTRL_GIE_BIT];
          peripheral_irq_enable_nxt = hwdata[`CCF_CTRL_PERIPHERAL_IRQ_ENABLE_BIT];
        end
        `CCF_OFF_MODE:   channel_mode_select_nxt = hwdata[9:0];
        default:         enable_nxt = enable_r;
      endcase
    end
  end

  // Registers the software-owned configuration.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      enable_r                <= `CCF_ENABLE_RST;
      global_irq_enable_r     <= 1'b0;
      peripheral_irq_enable_r <= 1'b0;
      channel_mode_select_r   <= `CCF_MODE_RST;
    end
    else
    begin
      enable_r                <= enable_nxt;
      global_irq_enable_r     <= global_irq_enable_nxt;
      peripheral_irq_enable_r <= peripheral_irq_enable_nxt;
      channel_mode_select_r   <= channel_mode_select_nxt;
    end
  end

  // Selects each channel's event from its mode.
  ccf_evt_sel #(
    .N         (`CCF_NUM_CHAN)
  ) u_evt (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .mode      (channel_mode_select_r),
    .cap_event (cap_event),
    .cmp_match (cmp_match),
    .pwm_out   (pwm_out),
    .evt       (evt)
  );

  // Event sets ignore every enable; only a written zero clears.
  ccf_flag_bank #(
    .N       (`CCF_NUM_CHAN)
  ) u_flags (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set     (evt),
    .wr_en   (flag_wr),
    .wr_data (hwdata[4:0]),
    .flags   (flags)
  );

  // Flag outputs, channel n at bit n-1.
  assign chan1_event_flag = flags[0];
  assign chan2_event_flag = flags[1];
  assign chan3_event_flag = flags[2];
  assign chan4_event_flag = flags[3];
  assign chan5_event_flag = flags[4];

  // Interrupt request needs a flagged, enabled channel and both enables.
  always_comb
  begin
    irq_nxt = (|(flags & enable_r)) & peripheral_irq_enable_r
              & global_irq_enable_r;
  end

  // Registers the interrupt output.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_r <= 1'b0;
    else
      irq_r <= irq_nxt;
  end

  assign irq = irq_r;

  // Checks on flag, request and bus behaviour.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_flag_sets_evt: assert property (
    (|evt) |=> ((flags & $past(evt)) == $past(evt)))
    else $error("event did not set its flag");

  a_flag_holds: assert property (
    !flag_wr |=> ((flags & $past(flags)) == $past(flags)))
    else $error("flag dropped without a software write");

  a_chan4_bit3: assert property (
    (channel_mode_select_r[7:6] == 2'h1 && cap_event[3])
      |=> chan4_event_flag && flags[3])
    else $error("channel four capture did not set bit three");

  a_set_no_enable: assert property (
    (evt[0] && !enable_r[0]) |=> flags[0])
    else $error("disabled channel flag was not set");

  a_set_no_gie: assert property (
    (evt[1] && !global_irq_enable_r) |=> flags[1])
    else $error("flag not set with global enable off");

  a_irq_gated: assert property (
    irq |-> $past(global_irq_enable_r) && $past(peripheral_irq_enable_r)
            && ($past(flags & enable_r) != 5'h00))
    else $error("interrupt raised without all its enables");

  a_irq_rises: assert property (
    ((|(flags & enable_r)) && peripheral_irq_enable_r
      && global_irq_enable_r) |=> irq)
    else $error("interrupt missing for enabled pending flag");

  a_pwm_fall_set: assert property (
    (channel_mode_select_r[1:0] == 2'h3 && channel_mode_select_r[1:0]
      == $past(channel_mode_select_r[1:0]) && $fell(pwm_out[0]))
      |=> flags[0])
    else $error("PWM trailing edge did not set the flag");

  a_read_wait: assert property (
    (accept && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  a_write_no_wait: assert property (
    (accept && hwrite) |=> hreadyout)
    else $error("write data phase was held");

  a_sw_write_loads: assert property (
    flag_wr |=> (flags == ($past(hwdata[4:0]) | $past(evt))))
    else $error("flag write did not load its value");

  a_irq_drops: assert property (
    !((|(flags & enable_r)) && peripheral_irq_enable_r
      && global_irq_enable_r) |=> !irq)
    else $error("interrupt stayed up without its enables");

  a_mode_off_quiet: assert property (
    (channel_mode_select_r[1:0] == 2'h0) |-> !evt[0])
    else $error("channel in off mode raised an event");

  c_capture_set: cover property (
    channel_mode_select_r[1:0] == 2'h1 && cap_event[0] ##1 flags[0]);

  c_sw_clear: cover property (flags[2] && flag_wr && !hwdata[2] ##1 !flags[2]);

  c_irq_rise: cover property ($rose(irq));

  c_set_beats_clear: cover property (flag_wr && evt[0] && !hwdata[0]);

endmodule

/* File: verilog/ccf_map.svh */
/*
  Register offsets, field positions and reset values of the capture and
  compare flag block.
  Assumes byte addresses on a 32-bit AHB-Lite bus, one register a word.
*/
`ifndef CCF_MAP_SVH
`define CCF_MAP_SVH

// Number of channels and width of one mode field.
`define CCF_NUM_CHAN      5
`define CCF_MODE_W        2

// Register byte offsets.
`define CCF_OFF_FLAGS     8'h00
`define CCF_OFF_ENABLE    8'h04
`define CCF_OFF_CTRL      8'h08
`define CCF_OFF_MODE      8'h0c

// Field positions in the control register.
`define CCF_CTRL_GIE_BIT  7
`define CCF_CTRL_PERIPHERAL_IRQ_ENABLE_BIT 6

// Reset values.
`define CCF_FLAGS_RST     5'h00
`define CCF_ENABLE_RST    5'h00
`define CCF_CTRL_RST      2'h0
`define CCF_MODE_RST      10'h000

`endif

/* File: verilog/ccf_pkg.sv */
/*
  Types shared by the capture and compare flag block.
  Assumes nothing of its surroundings.
*/
package ccf_pkg;

  // Per-channel operating mode.
  typedef enum logic [1:0] {
    mode_off     = 2'h0,
    mode_capture = 2'h1,
    mode_compare = 2'h2,
    mode_pwm     = 2'h3
  } ccf_mode_t;

  // Bus slave phase, one-hot.
  typedef enum logic [3:0] {
    bus_idle  = 4'h1,
    bus_wdata = 4'h2,
    bus_rwait = 4'h4,
    bus_rdone = 4'h8
  } ccf_bus_st_t;

endpackage
